/* File: design/psthd_channel.sv */
// Purpose: one pulse channel with stop, ramp and homing direction
// Assumes: inputs already synchronised by the top
// Notes: ramp is a stretch of the half period, not a profile

`timescale 1ns/1ps

module psthd_channel (
	input wire logic clock, // system clock
	input wire logic reset_n, // async reset, active low
	input wire logic present, // channel fitted
	input wire logic opActive, // operation command level
	input wire psthd_pkg::psthd_op_t opKind, // operation kind
	input wire logic immediateStop, // immediate stop bit
	input wire logic homeForwardSel, // dog homing forward select
	input wire logic rampEnable, // variable speed ramp enable
	input wire logic fwdLimit, // forward limit bit
	input wire logic revLimit, // reverse limit bit
	input wire logic limitsFitted, // limit inputs provided
	output logic pulseOut, // pulse train
	output logic dirOut, // direction, high = forward
	output logic busy, // pulses being emitted
	output logic doneFlag, // one-cycle completion pulse
	output logic abnormalFlag, // one-cycle abnormal end pulse
	output logic [psthd_pkg::PSTHD_POS_W-1:0] position // current position
);
	import psthd_pkg::*;

	psthd_state_t state_q, state_d;
	logic [PSTHD_CNT_W-1:0] cnt_q;
	logic [PSTHD_CNT_W-1:0] stretch_q;
	logic lastActive_q;
	logic dir_q;

	wire startEdge = opActive && !lastActive_q && present;
	wire dogBlocked = (opKind == PSTHD_OP_DOG_HOME) && !limitsFitted;
	wire ramped = (opKind != PSTHD_OP_VARSPEED) || rampEnable;
	wire limitHit = limitsFitted && (dir_q ? fwdLimit : revLimit);
	wire stopReq = !opActive || limitHit;
	wire halfDone = (cnt_q == '0);
	wire [PSTHD_CNT_W-1:0] reload = (PSTHD_CNT_W)'(PSTHD_HALF_CYC) + stretch_q;
	// dog homing keeps its start direction; plain homing always reverse
	wire startDir = (opKind == PSTHD_OP_DOG_HOME) ? homeForwardSel :
		(opKind == PSTHD_OP_PLAIN_HOME) ? 1'b0 : 1'b1;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			PSTHD_IDLE: begin
				if (startEdge && !immediateStop && !dogBlocked) begin
					state_d = PSTHD_RUN;
				end
			end
			PSTHD_RUN: begin
				if (immediateStop) begin
					state_d = PSTHD_HALTED;
				end else if (stopReq) begin
					state_d = ramped ? PSTHD_DECEL : PSTHD_IDLE;
				end
			end
			PSTHD_DECEL: begin
				if (immediateStop) begin
					state_d = PSTHD_HALTED;
				end else if (stretch_q >= (PSTHD_CNT_W)'(PSTHD_RAMP_MAX)) begin
					state_d = PSTHD_DONE;
				end
			end
			// resume needs stop clear, then op off, then op on again
			PSTHD_HALTED: begin
				if (!immediateStop && !opActive) begin
					state_d = PSTHD_IDLE;
				end
			end
			PSTHD_DONE: begin
				if (!opActive) begin
					state_d = PSTHD_IDLE;
				end
			end
			default: state_d = PSTHD_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= PSTHD_IDLE;
			lastActive_q <= 1'b0;
		end else begin
			state_q <= present ? state_d : PSTHD_IDLE;
			lastActive_q <= opActive;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= '0;
			stretch_q <= '0;
			pulseOut <= 1'b0;
			dir_q <= 1'b0;
		end else if (state_q == PSTHD_IDLE) begin
			cnt_q <= (PSTHD_CNT_W)'(PSTHD_HALF_CYC);
			stretch_q <= '0;
			pulseOut <= 1'b0;
			if (startEdge) begin
				dir_q <= startDir;
			end
		end else if (state_d == PSTHD_RUN || state_d == PSTHD_DECEL) begin
			cnt_q <= halfDone ? reload : cnt_q - 1'b1;
			if (halfDone) begin
				pulseOut <= !pulseOut;
				if (state_q == PSTHD_DECEL && pulseOut) begin
					stretch_q <= stretch_q + (PSTHD_CNT_W)'(PSTHD_RAMP_STEP);
				end
			end
		end else begin
			pulseOut <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			position <= PSTHD_POS_RESET;
			busy <= 1'b0;
			dirOut <= 1'b0;
			doneFlag <= 1'b0;
			abnormalFlag <= 1'b0;
		end else begin
			busy <= (state_d == PSTHD_RUN) || (state_d == PSTHD_DECEL);
			dirOut <= dir_q;
			doneFlag <= (state_q == PSTHD_DECEL && state_d == PSTHD_DONE) ||
				(state_q == PSTHD_RUN && state_d == PSTHD_IDLE);
			abnormalFlag <= (state_d == PSTHD_HALTED &&
				state_q != PSTHD_HALTED) ||
				(state_q == PSTHD_IDLE && startEdge && dogBlocked);
			// count on the rising edge of each output pulse
			if (halfDone && !pulseOut &&
				(state_d == PSTHD_RUN || state_d == PSTHD_DECEL)) begin
				position <= dir_q ? position + 1'b1 : position - 1'b1;
			end
		end
	end

endmodule : psthd_channel

/* File: common/psthd_pkg.sv */
// Purpose: constants for the pulse stop and homing direction block
// Assumes: 100 MHz clock, four pulse channels
// Notes: pulse period and position width are plain defaults

package psthd_pkg;

	// ----------------------------------------------------------------
	// channel structure
	// ----------------------------------------------------------------
	localparam int PSTHD_NCH = 4;
	localparam int PSTHD_POS_W = 32;
	localparam logic [31:0] PSTHD_POS_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// pulse timing (cycles of the 100 MHz clock)
	// ----------------------------------------------------------------
	localparam int PSTHD_CLK_MHZ = 100;
	localparam int PSTHD_HALF_NS = 500;
	localparam int PSTHD_HALF_CYC = (PSTHD_HALF_NS * PSTHD_CLK_MHZ) / 1000;
	localparam int PSTHD_CNT_W = 16;
	localparam int PSTHD_RAMP_STEP = 8;
	localparam int PSTHD_RAMP_MAX = 64;

	// ----------------------------------------------------------------
	// operation kinds and channel states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PSTHD_OP_POSITION,
		PSTHD_OP_VARSPEED,
		PSTHD_OP_DOG_HOME,
		PSTHD_OP_PLAIN_HOME
	} psthd_op_t;

	typedef enum logic [2:0] {
		PSTHD_IDLE,
		PSTHD_RUN,
		PSTHD_DECEL,
		PSTHD_HALTED,
		PSTHD_DONE
	} psthd_state_t;

endpackage : psthd_pkg

/* File: design/psthd_top.sv */
// Purpose: four channel pulse output with immediate stop and homing
// Assumes: command bits come from controller pins, synchronised here
// Notes: no register bus; every control bit is a plain port
//
// Contract
// - immediate stop halts pulses at once with no ramp
// - resume needs stop cleared, operation off, then on again
// - each channel has its own stop bit affecting only itself
// - channel three works only when its adapters are fitted
// - variable speed without ramp stops at once on off or limit
// - dog homing goes forward when select set, reverse otherwise
// - dog homing keeps the direction chosen at start
// - plain homing moves reverse and counts position down
// - without limit inputs pulses continue until operation is off
// - dog homing unavailable without limit inputs
// - ramped operations decelerate then stop on a limit
// - ramp enable clear gives variable speed without ramps

`timescale 1ns/1ps

module psthd_top (
	input wire logic clock, // 100 MHz system clock
	input wire logic reset_n, // async reset, active low
	input wire logic [3:0] opActive, // per channel operation command
	input wire logic [7:0] opKind, // two bits per channel
	input wire logic ch0_immediate_stop, // channel 0 stop
	input wire logic ch1_immediate_stop, // channel 1 stop
	input wire logic ch2_immediate_stop, // channel 2 stop
	input wire logic ch3_immediate_stop, // channel 3 stop
	input wire logic ch0_home_forward_sel, // channel 0 homing direction
	input wire logic ch1_home_forward_sel, // channel 1 homing direction
	input wire logic ch2_home_forward_sel, // channel 2 homing direction
	input wire logic ch3_home_forward_sel, // channel 3 homing direction
	input wire logic varspeed_ramp_enable, // ramp on for variable speed
	input wire logic [3:0] fwd_limit_input, // forward limit bits
	input wire logic [3:0] rev_limit_input, // reverse limit bits
	input wire logic limitsFitted, // limit inputs are provided
	input wire logic twoAdaptersFitted, // enables channel three
	output logic pulse_channel_0, // channel 0 pulses
	output logic pulse_channel_1, // channel 1 pulses
	output logic pulse_channel_2, // channel 2 pulses
	output logic pulse_channel_3, // channel 3 pulses
	output logic [3:0] directionOut, // direction, high = forward
	output logic [3:0] pulseActive, // channel busy monitors
	output logic [3:0] op_done_flag, // completion pulses
	output logic [3:0] op_abnormal_end_flag, // abnormal end pulses
	output logic [127:0] positionAll // four 32 bit positions
);
	import psthd_pkg::*;

	localparam int NIN = 4 + 8 + 4 + 4 + 1 + 4 + 4 + 2;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	wire [NIN-1:0] rawIn = {opActive, opKind,
		ch3_immediate_stop, ch2_immediate_stop,
		ch1_immediate_stop, ch0_immediate_stop,
		ch3_home_forward_sel, ch2_home_forward_sel,
		ch1_home_forward_sel, ch0_home_forward_sel,
		varspeed_ramp_enable, fwd_limit_input, rev_limit_input,
		limitsFitted, twoAdaptersFitted};
	logic [NIN-1:0] meta_q, sync_q;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= rawIn;
			sync_q <= meta_q;
		end
	end

	wire [3:0] sOp = sync_q[30:27];
	wire [7:0] sKind = sync_q[26:19];
	wire [3:0] sStop = sync_q[18:15];
	wire [3:0] sHomeFwd = sync_q[14:11];
	wire sRamp = sync_q[10];
	wire [3:0] sFwd = sync_q[9:6];
	wire [3:0] sRev = sync_q[5:2];
	wire sLimFit = sync_q[1];
	wire [3:0] present = {sync_q[0], 3'b111};

	wire [3:0] pulseW, dirW, busyW, doneW, abnW;
	wire [127:0] posW;

	// ----------------------------------------------------------------
	// channels
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < PSTHD_NCH; g++) begin : gCh
			psthd_channel uCh (
				.clock(clock),
				.reset_n(reset_n),
				.present(present[g]),
				.opActive(sOp[g]),
				.opKind(psthd_op_t'(sKind[2*g +: 2])),
				.immediateStop(sStop[g]),
				.homeForwardSel(sHomeFwd[g]),
				.rampEnable(sRamp),
				.fwdLimit(sFwd[g]),
				.revLimit(sRev[g]),
				.limitsFitted(sLimFit),
				.pulseOut(pulseW[g]),
				.dirOut(dirW[g]),
				.busy(busyW[g]),
				.doneFlag(doneW[g]),
				.abnormalFlag(abnW[g]),
				.position(posW[32*g +: 32])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// output registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pulse_channel_0 <= 1'b0;
			pulse_channel_1 <= 1'b0;
			pulse_channel_2 <= 1'b0;
			pulse_channel_3 <= 1'b0;
			directionOut <= '0;
			pulseActive <= '0;
			op_done_flag <= '0;
			op_abnormal_end_flag <= '0;
			positionAll <= '0;
		end else begin
			pulse_channel_0 <= pulseW[0];
			pulse_channel_1 <= pulseW[1];
			pulse_channel_2 <= pulseW[2];
			pulse_channel_3 <= pulseW[3];
			directionOut <= dirW;
			pulseActive <= busyW;
			op_done_flag <= doneW;
			op_abnormal_end_flag <= abnW;
			positionAll <= posW;
		end
	end

endmodule : psthd_top

/* File: tb/psthd_servo_model.sv */
// Purpose: amplifier side, counts pulses by direction
// Assumes: direction settled before each pulse edge
// Notes: signed count, forward adds one

`timescale 1ns/1ps

module psthd_servo_model (
	input wire logic reset_n, // clears the counts
	input wire logic [3:0] pulses, // pulse trains
	input wire logic [3:0] dirs, // high = forward
	output logic [127:0] moved // four 32 bit step counts
);
	for (genvar g = 0; g < 4; g++) begin : gCount
		always @(posedge pulses[g] or negedge reset_n) begin
			if (!reset_n)
				moved[32*g +: 32] <= 32'h0000_0000;
			else if (dirs[g])
				moved[32*g +: 32] <= moved[32*g +: 32] + 32'h0000_0001;
			else
				moved[32*g +: 32] <= moved[32*g +: 32] - 32'h0000_0001;
		end
	end
endmodule : psthd_servo_model

/* File: tb/psthd_props.sv */
// Purpose: port checks for the pulse stop and homing block
// Assumes: inputs pass two sync flops, so effects lag a few edges
// Notes: bound to every top instance

`timescale 1ns/1ps

module psthd_props (
	input wire logic clock, // clock
	input wire logic reset_n, // reset
	input wire logic [3:0] opActive, // commands
	input wire logic [7:0] opKind, // kinds
	input wire logic ch0_immediate_stop, // stop 0
	input wire logic ch1_home_forward_sel, // select 1
	input wire logic varspeed_ramp_enable, // ramp
	input wire logic [3:0] fwd_limit_input, // limits
	input wire logic limitsFitted, // limits fitted
	input wire logic twoAdaptersFitted, // channel 3 on
	input wire logic pulse_channel_0, // pulses 0
	input wire logic pulse_channel_3, // pulses 3
	input wire logic [3:0] directionOut, // directions
	input wire logic [3:0] pulseActive, // busy
	input wire logic [3:0] op_abnormal_end_flag, // abnormal
	input wire logic [127:0] positionAll // positions
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	wire [31:0] pos2 = positionAll[95:64];

	sequence sDogRefused;
		$rose(opActive[1]) && opKind[3:2] == 2'd2 && !limitsFitted;
	endsequence
	sequence sAbnormalSoon;
		##[2:6] op_abnormal_end_flag[1];
	endsequence
	sequence sRunNoLimits;
		(pulseActive[0] && opActive[0] && !limitsFitted &&
			!ch0_immediate_stop) [*6];
	endsequence

	a_stop_halts_now: assert property (
		$rose(ch0_immediate_stop) && pulseActive[0] |->
		##[1:6] (!pulseActive[0] && !pulse_channel_0))
		else $error("stop did not halt channel 0");
	a_stop_blocks_start: assert property (
		ch0_immediate_stop [*6] ##0 !pulseActive[0] |=> !pulseActive[0])
		else $error("channel 0 started while stopped");
	a_ch3_absent: assert property (
		!twoAdaptersFitted [*6] |-> !pulseActive[3] && !pulse_channel_3)
		else $error("channel 3 active without adapters");
	a_dog_dir_select: assert property (
		$rose(pulseActive[1]) && opKind[3:2] == 2'd2 |->
		##[0:2] directionOut[1] == ch1_home_forward_sel)
		else $error("dog homing direction wrong");
	a_dog_dir_kept: assert property (
		pulseActive[1] [*3] |-> $stable(directionOut[1]))
		else $error("direction changed in mid run");
	a_count_by_dir: assert property (
		$changed(pos2) && pulseActive[2] |->
		pos2 == $past(pos2) + (directionOut[2] ? 32'h0000_0001 :
		32'hFFFF_FFFF))
		else $error("channel 2 position stepped wrongly");
	a_nolimit_runs: assert property (
		sRunNoLimits |=> pulseActive[0])
		else $error("channel 0 stopped without limit inputs");
	a_dog_refused: assert property (
		sDogRefused |-> sAbnormalSoon)
		else $error("refused dog homing gave no abnormal flag");
	a_noramp_stop: assert property (
		$fell(opActive[0]) && opKind[1:0] == 2'd1 && pulseActive[0] &&
		!varspeed_ramp_enable |-> ##[1:6] !pulseActive[0])
		else $error("variable speed did not stop at once");
	a_ramp_decel: assert property (
		$rose(fwd_limit_input[0]) && limitsFitted && pulseActive[0] &&
		varspeed_ramp_enable && opKind[1:0] == 2'd1 |-> pulseActive[0] [*8])
		else $error("ramped stop ended too early");
endmodule : psthd_props

bind psthd_top psthd_props u_props (.*);

/* File: tb/tb.sv */
// Purpose: directed run of stop, ramp and homing behaviour
// Assumes: inputs change at the falling edge only
// Notes: step counts are compared with the amplifier model

`timescale 1ns/1ps

module tb;
	logic clock = 0, reset_n = 1, ramp = 0, limFit = 1, twoAd = 1;
	logic [3:0] opA = 0, stp = 0, sel = 0, fwdL = 0, fDir = 0;
	logic [7:0] kind = 0;
	logic seenAbn;
	wire [3:0] pulse, dirO, act, done, abn;
	wire [127:0] pos, moved;
	int err_total = 0, n_checks = 0;

	always #5 clock = ~clock;

	psthd_top dut (.clock(clock), .reset_n(reset_n), .opActive(opA),
		.opKind(kind), .ch0_immediate_stop(stp[0]),
		.ch1_immediate_stop(stp[1]), .ch2_immediate_stop(stp[2]),
		.ch3_immediate_stop(stp[3]), .ch0_home_forward_sel(sel[0]),
		.ch1_home_forward_sel(sel[1]), .ch2_home_forward_sel(sel[2]),
		.ch3_home_forward_sel(sel[3]), .varspeed_ramp_enable(ramp),
		.fwd_limit_input(fwdL), .rev_limit_input(4'h0),
		.limitsFitted(limFit), .twoAdaptersFitted(twoAd),
		.pulse_channel_0(pulse[0]), .pulse_channel_1(pulse[1]),
		.pulse_channel_2(pulse[2]), .pulse_channel_3(pulse[3]),
		.directionOut(dirO), .pulseActive(act), .op_done_flag(done),
		.op_abnormal_end_flag(abn), .positionAll(pos));
	// controller may force the direction line for forward plain homing
	psthd_servo_model servo (.reset_n(reset_n), .pulses(pulse),
		.dirs(dirO | fDir), .moved(moved));

	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic go(input int g, input logic [1:0] k);
		kind[2*g +: 2] = k;
		opA[g] = 1;
		cyc(10);
	endtask : go
	task automatic toggle(input int g);
		opA[g] = 0;
		cyc(6);
		opA[g] = 1;
		cyc(10);
	endtask : toggle
	// bounded: decel of a few ramp steps fits well inside
	task automatic waitIdle(input int g);
		for (int n = 0; n < 4000 && act[g] !== 1'b0; n++) cyc(1);
	endtask : waitIdle
	// forward plain homing on channel 2: position counts down, motor forward
	task automatic fwdHome(input logic hard);
		logic [31:0] p0, m0;
		p0 = pos[95:64];
		m0 = moved[95:64];
		fDir[2] = 1;
		go(2, 2'd3);
		cyc(200);
		if (hard) begin
			stp[2] = 1; // hazard stop only
		end else begin
			opA[2] = 0;
		end
		for (int n = 0; n < 4000; n++) begin
			if (hard ? abn[2] : done[2]) break;
			cyc(1);
		end
		fDir[2] = 0;
		chk(hard ? abn[2] : done[2], 1);
		chk(moved[95:64] - m0, p0 - pos[95:64]);
		chk((p0 - pos[95:64]) != 0, 1);
		stp[2] = 0;
		opA[2] = 0;
		cyc(6);
	endtask : fwdHome
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (30000) @(posedge clock);
		err_total++;
		$display("unexpected at %0t: run hung", $time);
		tally_and_finish();
	end

	initial begin
		cyc(1);
		reset_n = 0;
		cyc(20);
		reset_n = 1;
		cyc(2);
		chk(act, 0);
		sel = 4'b0010;
		go(0, 2'd0);
		go(1, 2'd2);
		go(2, 2'd3);
		cyc(300);
		chk(dirO[2:0], 3'b011);
		sel = 0;
		cyc(200);
		chk(dirO[1], 1);
		stp[0] = 1; // hazard stop only
		cyc(6);
		chk({act[1:0], pulse[0]}, 3'b100);
		toggle(0);
		chk(act[0], 0);
		stp[0] = 0;
		cyc(6);
		chk(act[0], 0);
		toggle(0);
		chk(act[0], 1);
		opA = 0;
		for (int g = 0; g < 3; g++) waitIdle(g);
		chk(pos[95:64], moved[95:64]);
		chk(pos[95], 1);
		chk(pos[63:32], moved[63:32]);
		$display("test stop and direction done");
		fwdHome(0);
		fwdHome(1);
		$display("test forward homing done");
		go(0, 2'd1);
		cyc(200);
		opA[0] = 0;
		cyc(6);
		chk(act[0], 0);
		go(0, 2'd1);
		cyc(100);
		fwdL[0] = 1;
		cyc(6);
		chk(act[0], 0);
		opA[0] = 0;
		fwdL[0] = 0;
		ramp = 1;
		cyc(6);
		go(0, 2'd1);
		cyc(200);
		fwdL[0] = 1;
		cyc(30);
		chk(act[0], 1);
		waitIdle(0);
		chk(act[0], 0);
		opA[0] = 0;
		fwdL[0] = 0;
		$display("test ramp and limits done");
		limFit = 0;
		cyc(6);
		go(0, 2'd0);
		fwdL[0] = 1;
		cyc(300);
		chk(act[0], 1);
		opA[0] = 0;
		fwdL[0] = 0;
		waitIdle(0);
		seenAbn = 0;
		opA[1] = 1;
		for (int n = 0; n < 10; n++) begin
			cyc(1);
			seenAbn |= abn[1];
		end
		chk({seenAbn, act[1]}, 2'b10);
		opA[1] = 0;
		limFit = 1;
		$display("test missing limits done");
		twoAd = 0;
		go(3, 2'd0);
		cyc(300);
		chk(act[3], 0);
		chk(pos[127:96], 0);
		twoAd = 1;
		toggle(3);
		chk(act[3], 1);
		opA[3] = 0;
		waitIdle(3);
		$display("test channel three done");
		tally_and_finish();
	end
endmodule : tb
